// ### rtl/hip_pkg.sv
// package: register map, field positions and timing for homing/interpolation block
package hip_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_MODE   = 8'h00;
   localparam logic [7:0] OFF_CTRL   = 8'h04;
   localparam logic [7:0] OFF_STAT   = 8'h08;
   localparam logic [7:0] OFF_METH   = 8'h0c;
   localparam logic [7:0] OFF_BLKCUR = 8'h10;
   localparam logic [7:0] OFF_BLKMS  = 8'h14;
   localparam logic [7:0] OFF_IPMS   = 8'h18;
   localparam logic [7:0] OFF_TGTEN  = 8'h1c;
   localparam logic [7:0] OFF_TGT    = 8'h20;
   localparam logic [7:0] OFF_LIMLO  = 8'h24;
   localparam logic [7:0] OFF_LIMHI  = 8'h28;
   localparam logic [7:0] OFF_DEMAND = 8'h2c;
   // ---------------------------------------------------------------
   // field positions and codes
   // ---------------------------------------------------------------
   localparam int CTL_START   = 4;
   localparam int CTL_HALT    = 8;
   localparam int ST_REACHED  = 10;
   localparam int ST_LIMIT    = 11;
   localparam int ST_ACTIVE   = 12;
   localparam int ST_HOM_ERR  = 13;
   localparam logic [7:0] MODE_HOMING = 8'h06;
   localparam logic [7:0] MODE_INTERP = 8'h07;
   localparam logic [7:0] METH_HERE   = 8'h23;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  RST_MODE   = 8'h00;
   localparam logic [7:0]  RST_METH   = 8'h23;
   localparam logic [15:0] RST_BLKCUR = 16'hffff;
   localparam logic [15:0] RST_BLKMS  = 16'h0064;
   localparam logic [15:0] RST_IPMS   = 16'h0001;
   localparam logic [31:0] RST_LIMLO  = 32'h80000000;
   localparam logic [31:0] RST_LIMHI  = 32'h7fffffff;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   // decoded homing method
   typedef struct packed {
      logic use_index;
      logic on_block;
      logic at_here;
      logic lim_ref;     // references a limit switch, or the block
      logic home_left;   // left edge of the home switch
      logic home_right;  // right edge of the home switch
      logic lim_pos;     // positive-side limit switch observed
      logic lim_neg;     // negative-side limit switch observed
   } hip_meth_t;
endpackage

// ### rtl/hip_motion.sv
// homing method decode, homing sequencer and interpolated position logic with apb registers
// Notes on behaviour
// R1 - homing on block only allowed in closed loop; refused in open loop
// R2 - on block: block seen when motor current exceeds threshold register
// R3 - after block seen, keep pushing for blocking duration in ms, then reached
// R4 - methods 1 to 14, 33, 34 use encoder index pulse
// R5 - methods 17 to 30 use switch edges only, no index pulse
// R6 - methods 33 and 34 reference only the next index pulse
// R7 - method 35 takes present position, needs no operation enabled state
// R8 - negative methods are on block; -1,-2,-7..-14 with index, others without
// R9 - methods 1/2 negative/positive limit plus index; 17/18 without index
// R10 - methods 3,4 left home edge; 5,6 right edge; then index pulse
// R11 - methods 7..10 watch positive limit, 11..14 negative limit
// R12 - mode selector value 7 enters interpolated position mode
// R13 - interpolation follows sync message once network state is operational
// R14 - control bit 4 activates interpolation
// R15 - control bit 8 halts; edges select start ramp or halt deceleration
// R16 - status bit 10: target reached if not halted, speed zero if halted
// R17 - status bit 11 set when demand lies outside software limits
// R18 - status bit 12 is one exactly while interpolation is active
// R19 - linear path from present position to single target position
// R20 - interpolation interval taken from period register in ms
// R21 - target position writes refused unless target enable is one
// R22 - controller writes each new target in time for the interval
// R23 - homing: bit 4 starts, runs until reference reached or bit cleared
// R24 - unsupported method numbers rejected, previous method kept
`timescale 1ns/1ps
module hip_motion #(
   parameter int MS_CYC = hip_pkg::MS_CYCLES
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                closed_loop,
   input  wire logic                op_enabled,
   input  wire logic                nmt_operational,
   input  wire logic                sync_pulse,
   input  wire logic [15:0]         motor_current,
   input  wire logic                axis_speed_zero,
   input  wire logic                ref_found,
   output hip_pkg::hip_meth_t       meth_info,
   output logic                     homing_run,
   output logic                     halt_brake,
   output logic                     start_ramp,
   output logic [31:0]              demand_pos
);
   import hip_pkg::*;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // supported method codes, positive and on-block negative
   function automatic logic meth_ok(input logic [7:0] m);
      logic [7:0] a;
      a = m[7] ? 8'(-m) : m;
      if (m[7])
         meth_ok = (a == 8'h01) || (a == 8'h02) || (a >= 8'h07 && a <= 8'h0e) ||
                   (a == 8'h11) || (a == 8'h12) || (a >= 8'h17 && a <= 8'h1e);
      else
         meth_ok = (a >= 8'h01 && a <= 8'h0e) || (a >= 8'h11 && a <= 8'h1e) ||
                   (a >= 8'h21 && a <= 8'h23);
   endfunction
   function automatic hip_meth_t meth_dec(input logic [7:0] m);
      logic [7:0] a;
      logic [7:0] b;
      a = m[7] ? 8'(-m) : m;
      // 17..30 share the travel profiles of 1..14, only the index use differs
      b = (a >= 8'h11 && a <= 8'h1e) ? a - 8'h10 : a;
      meth_dec.use_index  = (a >= 8'h01 && a <= 8'h0e) || (!m[7] && (a == 8'h21 || a == 8'h22));
      meth_dec.on_block   = m[7];
      meth_dec.at_here    = (m == METH_HERE);
      meth_dec.lim_ref    = (b == 8'h01) || (b == 8'h02);  // R9
      meth_dec.home_left  = (b == 8'h03) || (b == 8'h04);  // R10
      meth_dec.home_right = (b == 8'h05) || (b == 8'h06);  // R10
      meth_dec.lim_pos    = (b == 8'h02) || (b >= 8'h07 && b <= 8'h0a);  // R9 R11
      meth_dec.lim_neg    = (b == 8'h01) || (b >= 8'h0b && b <= 8'h0e);  // R9 R11
   endfunction
   // ---------------------------------------------------------------
   // apb slave
   // ---------------------------------------------------------------
   logic [7:0]  mode_ff, meth_ff;
   logic [31:0] ctrl_ff, tgt_ff, limlo_ff, limhi_ff, dem_ff;
   logic [15:0] blkcur_ff, blkms_ff, ipms_ff;
   logic        tgten_ff, pready_ff, pslverr_ff, reached_ff, limit_ff, active_ff, hom_err_ff;
   logic [31:0] prdata_ff;
   logic        wr, rd_hit;
   logic [31:0] rd_val;
   assign wr = psel && penable && pready_ff && pwrite;
   // one wait state: every access answers on its second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pready_ff <= 1'b0;
      else
         pready_ff <= psel && penable && !pready_ff;
   end
   // read mux and unmapped detection
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0;
      case (paddr)
         OFF_MODE:   rd_val = {24'h0, mode_ff};
         OFF_CTRL:   rd_val = ctrl_ff;
         OFF_STAT:   rd_val = 32'(reached_ff) << ST_REACHED | 32'(limit_ff) << ST_LIMIT |
                              32'(active_ff) << ST_ACTIVE | 32'(hom_err_ff) << ST_HOM_ERR;
         OFF_METH:   rd_val = {24'h0, meth_ff};
         OFF_BLKCUR: rd_val = {16'h0, blkcur_ff};
         OFF_BLKMS:  rd_val = {16'h0, blkms_ff};
         OFF_IPMS:   rd_val = {16'h0, ipms_ff};
         OFF_TGTEN:  rd_val = {31'h0, tgten_ff};
         OFF_TGT:    rd_val = tgt_ff;
         OFF_LIMLO:  rd_val = limlo_ff;
         OFF_LIMHI:  rd_val = limhi_ff;
         OFF_DEMAND: rd_val = dem_ff;
         default:    rd_hit = 1'b0;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0;
         pslverr_ff <= 1'b0;
      end else if (psel && penable && !pready_ff) begin
         prdata_ff  <= pwrite ? 32'h0 : rd_val;
         pslverr_ff <= !rd_hit;
      end
   end
   // writable registers; rejected writes leave old value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff   <= RST_MODE;
         ctrl_ff   <= 32'h0;
         meth_ff   <= RST_METH;
         blkcur_ff <= RST_BLKCUR;
         blkms_ff  <= RST_BLKMS;
         ipms_ff   <= RST_IPMS;
         tgten_ff  <= 1'b0;
         tgt_ff    <= 32'h0;
         limlo_ff  <= RST_LIMLO;
         limhi_ff  <= RST_LIMHI;
      end else if (wr) begin
         case (paddr)
            OFF_MODE:   mode_ff   <= pwdata[7:0];
            OFF_CTRL:   ctrl_ff   <= pwdata;
            OFF_METH:   if (meth_ok(pwdata[7:0])) meth_ff <= pwdata[7:0];  // R24
            OFF_BLKCUR: blkcur_ff <= pwdata[15:0];
            OFF_BLKMS:  blkms_ff  <= pwdata[15:0];
            OFF_IPMS:   if (pwdata[15:0] != 16'h0) ipms_ff <= pwdata[15:0];
            OFF_TGTEN:  tgten_ff  <= pwdata[0];
            OFF_TGT:    if (tgten_ff) tgt_ff <= pwdata;  // R21
            OFF_LIMLO:  limlo_ff  <= pwdata;
            OFF_LIMHI:  limhi_ff  <= pwdata;
            default:    ;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // millisecond tick
   // ---------------------------------------------------------------
   logic [31:0] ms_cnt_ff;
   logic        ms_tick;
   assign ms_tick = (ms_cnt_ff == 32'(MS_CYC - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ms_cnt_ff <= 32'h0;
      else
         ms_cnt_ff <= ms_tick ? 32'h0 : ms_cnt_ff + 32'h1;
   end
   // ---------------------------------------------------------------
   // homing sequencer
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {H_IDLE, H_SEARCH, H_PUSH, H_DONE, H_ERR} hip_hst_t;
   hip_hst_t    hst_ff;
   hip_meth_t   dec;
   logic [15:0] push_ms_ff;
   logic        hom_go;
   assign dec    = meth_dec(meth_ff);  // R4 R5 R6 R8
   assign hom_go = (mode_ff == MODE_HOMING) && ctrl_ff[CTL_START];  // R23
   // decoded method to the motion core; switch/edge choice per code passes in the meth_info fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         meth_info <= '0;
      else
         meth_info <= dec;  // R9 R10 R11
   end
   // referencing runs while start bit held; dropping it aborts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hst_ff     <= H_IDLE;
         push_ms_ff <= 16'h0;
      end else begin
         case (hst_ff)
            H_IDLE:
               if (hom_go) begin
                  if (dec.at_here)
                     hst_ff <= H_DONE;  // R7
                  else if (dec.on_block && !closed_loop)
                     hst_ff <= H_ERR;  // R1
                  else if (op_enabled)
                     hst_ff <= H_SEARCH;
               end
            H_SEARCH:
               if (!hom_go)
                  hst_ff <= H_IDLE;  // R23
               else if (dec.on_block && motor_current > blkcur_ff) begin
                  hst_ff     <= H_PUSH;  // R2
                  push_ms_ff <= 16'h0;
               end else if (!dec.on_block && ref_found)
                  hst_ff <= H_DONE;
            H_PUSH:
               if (!hom_go)
                  hst_ff <= H_IDLE;
               else if (ms_tick && push_ms_ff >= blkms_ff)
                  hst_ff <= H_DONE;  // R3: partial first ms not counted, push never short
               else if (ms_tick)
                  push_ms_ff <= push_ms_ff + 16'h1;
            H_DONE, H_ERR:
               if (!hom_go)
                  hst_ff <= H_IDLE;
            default:
               hst_ff <= H_IDLE;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         homing_run <= 1'b0;
         hom_err_ff <= 1'b0;
      end else begin
         homing_run <= (hst_ff == H_SEARCH) || (hst_ff == H_PUSH);
         hom_err_ff <= (hst_ff == H_ERR);
      end
   end
   // ---------------------------------------------------------------
   // interpolated position
   // ---------------------------------------------------------------
   logic        ip_on, halt_q_ff;
   logic [15:0] left_ms_ff;
   logic [31:0] seg_tgt_ff;
   logic signed [31:0] step;
   // active only in mode 7, bit 4 set and network operational
   assign ip_on = (mode_ff == MODE_INTERP) && ctrl_ff[CTL_START] && nmt_operational;  // R12 R13 R14
   // remaining distance shared over remaining ms; last ms lands exactly
   assign step = (left_ms_ff == 16'h0) ? 32'sh0 :
                 $signed(seg_tgt_ff - dem_ff) / $signed({16'h0, left_ms_ff});  // R19
   // each sync opens a new segment of the configured length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seg_tgt_ff <= 32'h0;
         left_ms_ff <= 16'h0;
         dem_ff     <= 32'h0;
      end else if (!ip_on) begin
         left_ms_ff <= 16'h0;
         seg_tgt_ff <= dem_ff;
      end else if (sync_pulse) begin
         seg_tgt_ff <= tgt_ff;  // R22
         left_ms_ff <= ipms_ff;  // R20
      end else if (ms_tick && left_ms_ff != 16'h0 && !ctrl_ff[CTL_HALT]) begin
         dem_ff     <= dem_ff + 32'(step);  // R19
         left_ms_ff <= left_ms_ff - 16'h1;
      end
   end
   // halt falling edge drives the start ramp pulse; halt_brake follows the halt bit level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_q_ff  <= 1'b0;
         halt_brake <= 1'b0;
         start_ramp <= 1'b0;
      end else begin
         halt_q_ff  <= ctrl_ff[CTL_HALT];
         halt_brake <= ctrl_ff[CTL_HALT];  // R15
         start_ramp <= halt_q_ff && !ctrl_ff[CTL_HALT];  // R15
      end
   end
   // status flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reached_ff <= 1'b0;
         limit_ff   <= 1'b0;
         active_ff  <= 1'b0;
      end else begin
         reached_ff <= ctrl_ff[CTL_HALT] ? axis_speed_zero : (dem_ff == tgt_ff);  // R16
         limit_ff   <= ($signed(dem_ff) < $signed(limlo_ff)) ||
                       ($signed(dem_ff) > $signed(limhi_ff));  // R17
         active_ff  <= ip_on;  // R18
      end
   end
   assign prdata     = prdata_ff;
   assign pready     = pready_ff;
   assign pslverr    = pslverr_ff;
   assign demand_pos = dem_ff;
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   meth_reject_a: assert property (@(posedge pclk) disable iff (!presetn)  // R24
      wr && paddr == OFF_METH && !meth_ok(pwdata[7:0]) |=> $stable(meth_ff))
      else $error("bad method code accepted");
   tgt_lock_a: assert property (@(posedge pclk) disable iff (!presetn)  // R21
      wr && paddr == OFF_TGT && !tgten_ff |=> $stable(tgt_ff))
      else $error("target changed while locked");
   block_open_a: assert property (@(posedge pclk) disable iff (!presetn)  // R1
      hst_ff == H_IDLE && hom_go && dec.on_block && !closed_loop && !dec.at_here |=> hst_ff == H_ERR)
      else $error("block homing started in open loop");
   block_det_a: assert property (@(posedge pclk) disable iff (!presetn)  // R2
      hst_ff == H_SEARCH && hom_go && dec.on_block && motor_current > blkcur_ff |=> hst_ff == H_PUSH)
      else $error("block not detected");
   push_time_a: assert property (@(posedge pclk) disable iff (!presetn)  // R3
      hst_ff == H_PUSH && $past(hst_ff) == H_SEARCH |-> push_ms_ff == 16'h0)
      else $error("push timer not cleared");
   here_done_a: assert property (@(posedge pclk) disable iff (!presetn)  // R7
      hst_ff == H_IDLE && hom_go && dec.at_here |=> hst_ff == H_DONE ##1 !homing_run)
      else $error("method 35 not immediate");
   abort_hom_a: assert property (@(posedge pclk) disable iff (!presetn)  // R23
      (hst_ff == H_SEARCH || hst_ff == H_PUSH) && !hom_go |=> hst_ff == H_IDLE ##1 !homing_run)
      else $error("homing not aborted");
   ip_active_a: assert property (@(posedge pclk) disable iff (!presetn)  // R18
      ip_on |=> active_ff)
      else $error("active flag missing");
   halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)  // R15
      ctrl_ff[CTL_HALT] && !sync_pulse && ip_on |=> $stable(dem_ff))
      else $error("demand moved while halted");
   start_edge_a: assert property (@(posedge pclk) disable iff (!presetn)  // R15
      $fell(ctrl_ff[CTL_HALT]) |=> start_ramp ##1 !start_ramp)
      else $error("start ramp pulse wrong");
   limit_flag_a: assert property (@(posedge pclk) disable iff (!presetn)  // R17
      $signed(dem_ff) > $signed(limhi_ff) |=> limit_ff)
      else $error("limit flag missing");
   reach_halt_a: assert property (@(posedge pclk) disable iff (!presetn)  // R16
      ctrl_ff[CTL_HALT] && axis_speed_zero |=> reached_ff)
      else $error("reached flag missing while halted");

   lim_one_a: assert property (@(posedge pclk) disable iff (!presetn)  // R9
      meth_ff == 8'h01 |=> meth_info.lim_ref && meth_info.lim_neg && meth_info.use_index)
      else $error("method 1 decode wrong");

   home_edge_a: assert property (@(posedge pclk) disable iff (!presetn)  // R10
      meth_ff == 8'h15 |=> meth_info.home_right && !meth_info.use_index)
      else $error("method 21 decode wrong");

   lim_side_a: assert property (@(posedge pclk) disable iff (!presetn)  // R11
      meth_ff == 8'hf6 |=> meth_info.lim_pos && !meth_info.lim_neg && meth_info.on_block)
      else $error("method -10 decode wrong");

   index_only_a: assert property (@(posedge pclk) disable iff (!presetn)  // R6
      meth_ff == 8'h22 |=> meth_info.use_index && !meth_info.lim_ref && !meth_info.lim_pos && !meth_info.lim_neg)
      else $error("method 34 decode wrong");

   mode_gate_a: assert property (@(posedge pclk) disable iff (!presetn)  // R12
      mode_ff != MODE_INTERP |=> !active_ff)
      else $error("active outside interpolation mode");

   net_gate_a: assert property (@(posedge pclk) disable iff (!presetn)  // R13
      !nmt_operational |=> !active_ff)
      else $error("active without network operational");

   start_gate_a: assert property (@(posedge pclk) disable iff (!presetn)  // R14
      !ctrl_ff[CTL_START] |=> !active_ff)
      else $error("active without start bit");

   seg_land_a: assert property (@(posedge pclk) disable iff (!presetn)  // R19
      ip_on && !sync_pulse && ms_tick && left_ms_ff == 16'h1 && !ctrl_ff[CTL_HALT] |=> dem_ff == seg_tgt_ff)
      else $error("segment end missed target");

   seg_len_a: assert property (@(posedge pclk) disable iff (!presetn)  // R20
      ip_on && sync_pulse |=> left_ms_ff == $past(ipms_ff))
      else $error("segment length not from period");

   reach_run_a: assert property (@(posedge pclk) disable iff (!presetn)  // R16
      !ctrl_ff[CTL_HALT] && dem_ff == tgt_ff |=> reached_ff)
      else $error("reached flag missing at target");
endmodule

// ### sim/hip_ctrl_model.sv
// far-side motion controller model: network state and periodic sync messages
`timescale 1ns/1ps
module hip_ctrl_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        nmt_on,
   input  wire logic        sync_on,
   input  wire logic [31:0] period,
   output logic             nmt_operational,
   output logic             sync_pulse
);
   logic [31:0] cnt_ff;
   // sync at a fixed interval; targets are written by the bench in time for it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 32'h0;
         sync_pulse <= 1'b0;
         nmt_operational <= 1'b0;
      end else begin
         sync_pulse <= sync_on && (cnt_ff == 32'h0);
         cnt_ff <= (cnt_ff + 32'h1 >= period) ? 32'h0 : cnt_ff + 32'h1;
         nmt_operational <= nmt_on;
      end
   end
endmodule

// ### sim/hip_tb_top.sv
// self-checking bench for homing decode, homing on block and interpolation
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin failures++; \
   $display("ERROR %s exp=%0h got=%0h", nm, ex, gt); end end
module homing_and_interpolated_position_tb_top;
   import hip_pkg::*;
   localparam int MSC = 10;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, demand_pos, rd, tgt, d0;
   logic        pready, pslverr, err, homing_run, halt_brake, start_ramp, nmt_operational, sync_pulse;
   logic        closed_loop = 1'b0, op_enabled = 1'b0, axis_speed_zero = 1'b0, ref_found = 1'b0;
   logic        nmt_on = 1'b0, sync_on = 1'b0;
   logic [15:0] motor_current = 16'h0;
   logic [7:0]  ec;
   hip_meth_t   meth_info, exp_m;
   int          failures = 0, cmp_count = 0, n, ramps = 0, r0;
   integer      seed = 32'hed8c124f;

   always #5 pclk = ~pclk;
   // count ramp pulses so a one-cycle pulse is never missed between polls
   always @(posedge pclk) if (start_ramp === 1'b1) ramps++;

   hip_motion #(.MS_CYC(MSC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .closed_loop(closed_loop), .op_enabled(op_enabled),
      .nmt_operational(nmt_operational), .sync_pulse(sync_pulse), .motor_current(motor_current),
      .axis_speed_zero(axis_speed_zero), .ref_found(ref_found), .meth_info(meth_info),
      .homing_run(homing_run), .halt_brake(halt_brake), .start_ramp(start_ramp), .demand_pos(demand_pos));
   hip_ctrl_model ctrl (.pclk(pclk), .presetn(presetn), .nmt_on(nmt_on), .sync_on(sync_on),
      .period(32'(2 * MSC)), .nmt_operational(nmt_operational), .sync_pulse(sync_pulse));

   task automatic stop_test();
      if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic lim_chk(input int k, input int lim);
      if (k >= lim) begin
         failures++;
         stop_test();
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd = prdata;
      err = pslverr;
      lim_chk(k, 16);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge pclk);
   endtask
   function automatic logic sup(input int m);
      return (m >= 1 && m <= 14) || (m >= 17 && m <= 30) || (m >= 33 && m <= 35) || m == -1 || m == -2 ||
             (m <= -7 && m >= -14) || m == -17 || m == -18 || (m <= -23 && m >= -30);
   endfunction
   function automatic hip_meth_t dec(input int m);
      int b;
      b = (m < 0) ? -m : m;
      if (b >= 17 && b <= 30) b = b - 16;  // same travel profiles as 1..14
      return '{use_index: (m >= 1 && m <= 14) || m == 33 || m == 34 || m == -1 || m == -2 ||
               (m <= -7 && m >= -14), on_block: m < 0, at_here: m == 35,
               lim_ref: b == 1 || b == 2, home_left: b == 3 || b == 4, home_right: b == 5 || b == 6,
               lim_pos: b == 2 || (b >= 7 && b <= 10), lim_neg: b == 1 || (b >= 11 && b <= 14)};
   endfunction

   initial begin
      tick(8);
      presetn <= 1'b1;
      tick(1);
      // ----------------------------------------
      // registers and method decode
      // ----------------------------------------
      apb(1'b0, OFF_METH, 32'h0); `CHK("meth_rst", {24'h0, RST_METH}, rd)
      apb(1'b0, OFF_LIMLO, 32'h0); `CHK("limlo_rst", RST_LIMLO, rd)
      apb(1'b0, 8'h30, 32'h0); `CHK("unmapped_err", 1'b1, err)
      apb(1'b1, OFF_TGT, 32'h55);
      apb(1'b0, OFF_TGT, 32'h0); `CHK("tgt_locked", 32'h0, rd)
      apb(1'b1, OFF_IPMS, 32'h0);
      apb(1'b0, OFF_IPMS, 32'h0); `CHK("ipms_zero", {16'h0, RST_IPMS}, rd)
      exp_m = dec(35);
      ec = RST_METH;
      for (int m = -128; m < 128; m++) begin
         apb(1'b1, OFF_METH, {24'h0, 8'(m)});
         if (sup(m)) begin
            exp_m = dec(m);
            ec = 8'(m);
         end
         tick(2);
         `CHK("meth_info", exp_m, meth_info)
         apb(1'b0, OFF_METH, 32'h0); `CHK("meth_code", {24'h0, ec}, rd)
      end
      // homing on block: equal current is not a block, one above is
      apb(1'b1, OFF_BLKCUR, 32'd100);
      apb(1'b1, OFF_BLKMS, 32'd1);
      apb(1'b1, OFF_MODE, {24'h0, MODE_HOMING});
      apb(1'b1, OFF_METH, 32'hff);
      closed_loop <= 1'b1;
      op_enabled <= 1'b1;
      motor_current <= 16'd100;
      apb(1'b1, OFF_CTRL, 32'h10);
      tick(3 * MSC); `CHK("homing_run", 1'b1, homing_run)
      motor_current <= 16'd101;
      n = 0;
      while (homing_run !== 1'b0 && n < 2 * MSC + 8) begin
         tick(1);
         n++;
      end
      lim_chk(n, 2 * MSC + 8); `CHK("push_time", 1'b1, n >= MSC)
      apb(1'b1, OFF_CTRL, 32'h0);
      closed_loop <= 1'b0;
      apb(1'b1, OFF_CTRL, 32'h10);
      tick(3);
      apb(1'b0, OFF_STAT, 32'h0); `CHK("open_loop_err", 1'b1, rd[ST_HOM_ERR])
      `CHK("open_loop_run", 1'b0, homing_run)
      apb(1'b1, OFF_CTRL, 32'h0);
      closed_loop <= 1'b1;
      // index-only method: runs until the reference is hit
      apb(1'b1, OFF_METH, 32'h21);
      apb(1'b1, OFF_CTRL, 32'h10);
      tick(3); `CHK("index_run", 1'b1, homing_run)
      ref_found <= 1'b1;
      tick(3); `CHK("index_done", 1'b0, homing_run)
      apb(1'b1, OFF_CTRL, 32'h0);
      // ----------------------------------------
      // interpolated position mode
      // ----------------------------------------
      d0 = demand_pos;
      tgt = 32'd60 + ($random(seed) & 32'h3ff);
      apb(1'b1, OFF_MODE, {24'h0, MODE_INTERP});
      apb(1'b1, OFF_IPMS, 32'd2);
      apb(1'b1, OFF_TGTEN, 32'h1);
      apb(1'b1, OFF_TGT, tgt);
      apb(1'b1, OFF_LIMHI, 32'd50);
      apb(1'b1, OFF_CTRL, 32'h10);
      sync_on <= 1'b1;
      tick(6 * MSC); `CHK("no_sync_follow", d0, demand_pos)
      apb(1'b0, OFF_STAT, 32'h0); `CHK("active_off", 1'b0, rd[ST_ACTIVE])
      nmt_on <= 1'b1;
      tick(3);
      apb(1'b0, OFF_STAT, 32'h0); `CHK("active_on", 1'b1, rd[ST_ACTIVE])
      for (int i = 0; i < 2; i++) begin
         n = 0;
         while (demand_pos !== tgt && n < 16 * MSC) begin
            tick(1);
            n++;
         end
         lim_chk(n, 16 * MSC); `CHK("demand", tgt, demand_pos)
         if (i == 0) begin
            apb(1'b0, OFF_STAT, 32'h0); `CHK("reached", 1'b1, rd[ST_REACHED])
            `CHK("limit_hi", 1'b1, rd[ST_LIMIT])
            apb(1'b1, OFF_LIMHI, RST_LIMHI);
            apb(1'b0, OFF_STAT, 32'h0); `CHK("limit_ok", 1'b0, rd[ST_LIMIT])
            tgt = 32'd60 + ($random(seed) & 32'h3ff);
            apb(1'b1, OFF_TGT, tgt);
         end
      end
      // halt: brake, frozen demand, speed-zero reached, ramp pulse on release
      r0 = ramps;
      d0 = demand_pos;
      apb(1'b1, OFF_CTRL, 32'h110);
      apb(1'b1, OFF_TGT, tgt + 32'd40);
      tick(3); `CHK("halt_brake", 1'b1, halt_brake)
      tick(6 * MSC); `CHK("halt_frozen", d0, demand_pos)
      apb(1'b0, OFF_STAT, 32'h0); `CHK("halt_moving", 1'b0, rd[ST_REACHED])
      axis_speed_zero <= 1'b1;
      tick(2);
      apb(1'b0, OFF_STAT, 32'h0); `CHK("halt_still", 1'b1, rd[ST_REACHED])
      apb(1'b1, OFF_CTRL, 32'h10);
      tick(5); `CHK("start_ramp", r0 + 1, ramps)
      `CHK("brake_off", 1'b0, halt_brake)
      apb(1'b1, OFF_CTRL, 32'h0);
      tick(3);
      apb(1'b0, OFF_STAT, 32'h0); `CHK("active_end", 1'b0, rd[ST_ACTIVE])
      stop_test();
   end
endmodule
